// ---- inc/probe_pkg.sv ----
// constants for the two-channel position capture block
// assumes a single 50 MHz clock domain and synchronous inputs
package probe_pkg;
   // ****************************************
   // object indices of the cyclic data
   // ****************************************
   localparam logic [15:0] IDX_FAST_FUNC = 16'h2003; // fast input functions
   localparam logic [15:0] IDX_CONTROL = 16'h60B8; // probe control word
   localparam logic [15:0] IDX_STATUS = 16'h60B9; // probe status word
   localparam logic [15:0] IDX_P1_RISE = 16'h60BA; // probe 1 rising pos
   localparam logic [15:0] IDX_P1_FALL = 16'h60BB; // probe 1 falling pos
   localparam logic [15:0] IDX_P2_RISE = 16'h60BC; // probe 2 rising pos
   localparam logic [15:0] IDX_P2_FALL = 16'h60BD; // probe 2 falling pos
   // ****************************************
   // control word fields, probe 2 sits 8 bits higher
   // ****************************************
   localparam int CTL_EN = 0; // enable
   localparam int CTL_MODE = 1; // 0 single, 1 continuous
   localparam int CTL_SRC = 2; // 0 fast input, 1 index pulse
   localparam int CTL_RISE = 4; // latch on rising edge
   localparam int CTL_FALL = 5; // latch on falling edge
   localparam int PROBE_STRIDE = 8; // bit distance between probes
   localparam logic [15:0] CONTROL_RESET = 16'h0000; // control reset
   // ****************************************
   // status word fields
   // ****************************************
   localparam int STS_EN = 0; // mirrors enable
   localparam int STS_RISE = 1; // rising capture done
   localparam int STS_FALL = 2; // falling capture done
   localparam logic [31:0] POS_RESET = 32'h00000000; // position reset
endpackage : probe_pkg

// ---- verilog/probe_edge_detect.sv ----
// one probe channel: trigger select and edge detection
// assumes trigger inputs already synchronous to clk_i
`timescale 1ns/1ps
module probe_edge_detect (
   input wire logic clk_i, // system clock
   input wire logic srst_i, // synchronous reset, high
   input wire logic src_sel_i, // 0 fast input, 1 index pulse
   input wire logic fast_in_i, // fast input level
   input wire logic index_in_i, // index pulse level
   output logic rise_o, // one-cycle rising pulse
   output logic fall_o // one-cycle falling pulse
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic prev; // last trigger level
      logic valid; // prev holds a real sample
   } edge_state_t;
   edge_state_t st; // current state
   edge_state_t next_st; // next state
   logic trig; // selected trigger level

   // source choice; a switch of source may look like an edge
   always_comb begin
      trig = src_sel_i ? index_in_i : fast_in_i;
      next_st.prev = trig;
      next_st.valid = 1'b1;
   end

   // edges only after the first sample, so reset gives no false edge
   assign rise_o = st.valid & trig & ~st.prev;
   assign fall_o = st.valid & ~trig & st.prev;

   // state register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : probe_edge_detect

// ---- verilog/probe_position_latch.sv ----
// two-channel touch probe that latches motor position on trigger edges
// assumes position, triggers and host writes synchronous to clk_i
`timescale 1ns/1ps
module probe_position_latch (
   input wire logic clk_i, // system clock, 50 MHz
   input wire logic srst_i, // synchronous reset, high
   input wire logic ctl_wr_i, // write strobe for control word
   input wire logic [15:0] ctl_wdata_i, // control word value
   input wire logic fast_input_one_i, // fast input 1 level
   input wire logic fast_input_two_i, // fast input 2 level
   input wire logic index_i, // encoder index pulse level
   input wire logic signed [31:0] motor_pos_i, // position, command units
   output logic [15:0] ctl_o, // control word readback
   output logic [15:0] status_o, // probe status word
   output logic signed [31:0] p1_rise_pos_o, // probe 1 rising position
   output logic signed [31:0] p1_fall_pos_o, // probe 1 falling position
   output logic signed [31:0] p2_rise_pos_o, // probe 2 rising position
   output logic signed [31:0] p2_fall_pos_o // probe 2 falling position
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [15:0] ctl; // control word
      logic [1:0] rise_flag; // rising capture done, per probe
      logic [1:0] fall_flag; // falling capture done, per probe
      logic [1:0][31:0] rise_pos; // rising positions
      logic [1:0][31:0] fall_pos; // falling positions
   } latch_state_t;
   latch_state_t st; // current state
   latch_state_t next_st; // next state
   logic [1:0] rise_ev; // rising edge seen
   logic [1:0] fall_ev; // falling edge seen
   logic [1:0] fast_in; // fast inputs per probe
   logic [1:0] src_sel; // source select per probe

   // field of probe p in the control word
   function automatic logic ctl_bit(input logic [15:0] c, input int p,
                                    input int f);
      ctl_bit = c[p * probe_pkg::PROBE_STRIDE + f];
   endfunction : ctl_bit

   assign fast_in = {fast_input_two_i, fast_input_one_i};

   // ****************************************
   // edge detection per probe
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_probe
         assign src_sel[g] = ctl_bit(st.ctl, g, probe_pkg::CTL_SRC);
         probe_edge_detect u_edge (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .src_sel_i(src_sel[g]),
            .fast_in_i(fast_in[g]),
            .index_in_i(index_i),
            .rise_o(rise_ev[g]),
            .fall_o(fall_ev[g])
         );
      end
   endgenerate

   // ****************************************
   // capture logic
   // ****************************************
   // flags clear on disable; host should set options before enabling
   always_comb begin
      logic en; // probe enabled
      logic cont; // continuous mode
      logic new_en; // enable after this write
      en = 1'b0;
      cont = 1'b0;
      new_en = 1'b0;
      next_st = st;
      if (ctl_wr_i) begin
         next_st.ctl = ctl_wdata_i;
      end
      for (int p = 0; p < 2; p++) begin
         en = ctl_bit(st.ctl, p, probe_pkg::CTL_EN);
         cont = ctl_bit(st.ctl, p, probe_pkg::CTL_MODE);
         new_en = ctl_bit(next_st.ctl, p, probe_pkg::CTL_EN);
         if (!new_en) begin
            // disable rearms single mode
            next_st.rise_flag[p] = 1'b0;
            next_st.fall_flag[p] = 1'b0;
         end else if (en) begin
            // rising capture, four registers kept apart
            if (rise_ev[p] && ctl_bit(st.ctl, p, probe_pkg::CTL_RISE)
                && (cont || !st.rise_flag[p])) begin
               next_st.rise_pos[p] = motor_pos_i;
               next_st.rise_flag[p] = 1'b1;
            end
            // falling capture
            if (fall_ev[p] && ctl_bit(st.ctl, p, probe_pkg::CTL_FALL)
                && (cont || !st.fall_flag[p])) begin
               next_st.fall_pos[p] = motor_pos_i;
               next_st.fall_flag[p] = 1'b1;
            end
         end
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st.ctl <= probe_pkg::CONTROL_RESET;
         st.rise_flag <= '0;
         st.fall_flag <= '0;
         st.rise_pos <= {2{probe_pkg::POS_RESET}};
         st.fall_pos <= {2{probe_pkg::POS_RESET}};
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // outputs, all registered
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctl_o <= '0;
         status_o <= '0;
         p1_rise_pos_o <= '0;
         p1_fall_pos_o <= '0;
         p2_rise_pos_o <= '0;
         p2_fall_pos_o <= '0;
      end else begin
         ctl_o <= next_st.ctl;
         status_o <= '0; // reserved bits read zero
         for (int p = 0; p < 2; p++) begin
            status_o[p * probe_pkg::PROBE_STRIDE + probe_pkg::STS_EN] <=
               ctl_bit(next_st.ctl, p, probe_pkg::CTL_EN);
            status_o[p * probe_pkg::PROBE_STRIDE + probe_pkg::STS_RISE] <=
               next_st.rise_flag[p];
            status_o[p * probe_pkg::PROBE_STRIDE + probe_pkg::STS_FALL] <=
               next_st.fall_flag[p];
         end
         p1_rise_pos_o <= next_st.rise_pos[0];
         p1_fall_pos_o <= next_st.fall_pos[0];
         p2_rise_pos_o <= next_st.rise_pos[1];
         p2_fall_pos_o <= next_st.fall_pos[1];
      end
   end

   // ****************************************
   // checks
   // ****************************************
   AST_P1_RISE_LATCH: assert property (@(posedge clk_i) disable iff (srst_i)
      rise_ev[0] && st.ctl[0] && st.ctl[4] && !ctl_wr_i
      && (st.ctl[1] || !st.rise_flag[0])
      |=> p1_rise_pos_o == $past(motor_pos_i) && status_o[1])
      else $error("probe 1 rising capture missed");
   AST_P2_FALL_LATCH: assert property (@(posedge clk_i) disable iff (srst_i)
      fall_ev[1] && st.ctl[8] && st.ctl[13] && !ctl_wr_i
      && (st.ctl[9] || !st.fall_flag[1])
      |=> p2_fall_pos_o == $past(motor_pos_i) && status_o[10])
      else $error("probe 2 falling capture missed");
   AST_SINGLE_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
      st.ctl[0] && !st.ctl[1] && st.rise_flag[0] && !ctl_wr_i
      |=> $stable(st.rise_pos[0]))
      else $error("single mode position changed");
   AST_DISABLE_CLEARS: assert property (@(posedge clk_i) disable iff (srst_i)
      ctl_wr_i && !ctl_wdata_i[8] |=> !status_o[9] && !status_o[10]
      && !status_o[8])
      else $error("disable left flags set");
   AST_NO_RISE_WHEN_OFF: assert property (@(posedge clk_i)
      disable iff (srst_i)
      !st.ctl[4] && !ctl_wr_i |=> $stable(st.rise_pos[0]))
      else $error("rising latch while not selected");
   AST_CONT_OVERWRITE: assert property (@(posedge clk_i) disable iff (srst_i)
      rise_ev[1] && st.ctl[8] && st.ctl[9] && st.ctl[12] && !ctl_wr_i
      |=> p2_rise_pos_o == $past(motor_pos_i))
      else $error("continuous overwrite missed");
   AST_STATUS_RESERVED: assert property (@(posedge clk_i)
      disable iff (srst_i)
      (status_o & 16'hF8F8) == 16'h0000)
      else $error("reserved status bit set");
   // each falling slot is judged by its own probe only, since both probes
   // may watch the shared index pulse and fall in the same cycle
   AST_FALL_SEPARATE: assert property (@(posedge clk_i) disable iff (srst_i)
      !fall_ev[0] |=> $stable(st.fall_pos[0]))
      else $error("probe 1 falling slot changed without its edge");
   AST_FALL_SEPARATE_P2: assert property (@(posedge clk_i)
      disable iff (srst_i)
      !fall_ev[1] |=> $stable(st.fall_pos[1]))
      else $error("probe 2 falling slot changed without its edge");
   AST_P1_FALL_LATCH: assert property (@(posedge clk_i) disable iff (srst_i)
      fall_ev[0] && st.ctl[0] && st.ctl[5] && !ctl_wr_i
      && (st.ctl[1] || !st.fall_flag[0])
      |=> p1_fall_pos_o == $past(motor_pos_i) && status_o[2])
      else $error("probe 1 falling capture missed");
   AST_P2_RISE_LATCH: assert property (@(posedge clk_i) disable iff (srst_i)
      rise_ev[1] && st.ctl[8] && st.ctl[12] && !ctl_wr_i
      && (st.ctl[9] || !st.rise_flag[1])
      |=> p2_rise_pos_o == $past(motor_pos_i) && status_o[9])
      else $error("probe 2 rising capture missed");
   AST_CTL_READBACK: assert property (@(posedge clk_i) disable iff (srst_i)
      ctl_wr_i |=> ctl_o == $past(ctl_wdata_i))
      else $error("control readback differs from write");
   // a latch flag never outlives the enable of its probe
   AST_P1_FLAG_NEEDS_EN: assert property (@(posedge clk_i)
      disable iff (srst_i)
      (status_o[1] || status_o[2]) |-> status_o[0])
      else $error("probe 1 flag set while disabled");
   AST_P2_FLAG_NEEDS_EN: assert property (@(posedge clk_i)
      disable iff (srst_i)
      (status_o[9] || status_o[10]) |-> status_o[8])
      else $error("probe 2 flag set while disabled");
endmodule : probe_position_latch

// ---- sim/probe_motor_model.sv ----
// motor side model: a moving position for the capture block to latch
// assumes the bench clock and a synchronous active-high reset
`timescale 1ns/1ps
module probe_motor_model #(
   parameter logic [31:0] POS_START = 32'hFFFFFFF0, // negative start
   parameter logic [31:0] POS_STEP = 32'h00000003 // counts per cycle
) (
   input wire logic clk_i, // bench clock
   input wire logic srst_i, // synchronous reset, high
   output logic signed [31:0] motor_pos_o // position, command units
);
   // ****************************************
   // position counter
   // ****************************************
   // moves every cycle so a capture one cycle off shows up as a mismatch
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         motor_pos_o <= POS_START; // start below zero to exercise sign
      end else begin
         motor_pos_o <= motor_pos_o + POS_STEP;
      end
   end
endmodule : probe_motor_model

// ---- sim/probe_position_latch_tb.sv ----
// self-checking bench for the two-channel position capture block
// assumes the motor model drives position; the bench acts as host
`timescale 1ns/1ps
module probe_position_latch_tb;
   // ****************************************
   // signals and bookkeeping
   // ****************************************
   logic clk_i = 1'b0; // bench clock
   logic srst_i = 1'b1; // reset held at start
   logic ctl_wr_i = 1'b0; // control write strobe
   logic [15:0] ctl_wdata_i = 16'h0000; // control write data
   logic [2:0] trig = 3'h0; // index, fast two, fast one
   logic signed [31:0] motor_pos; // from the motor model
   logic [15:0] ctl_o; // control readback
   logic [15:0] status_o; // status word
   logic signed [31:0] pos_o [4]; // latched positions
   logic signed [31:0] exp_pos [4] = '{default: 32'h00000000}; // expected
   logic signed [31:0] p; // position at the last trigger change
   int mismatches = 0; // failed compares
   int checks = 0; // compares made
   int cycles = 0; // hang guard
   // ****************************************
   // clock, timeout and instances
   // ****************************************
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   // the whole run needs about a hundred cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         final_report();
      end
   end
   probe_motor_model motor (.clk_i(clk_i), .srst_i(srst_i),
      .motor_pos_o(motor_pos));
   probe_position_latch dut (.clk_i(clk_i), .srst_i(srst_i),
      .ctl_wr_i(ctl_wr_i), .ctl_wdata_i(ctl_wdata_i),
      .fast_input_one_i(trig[0]), .fast_input_two_i(trig[1]),
      .index_i(trig[2]), .motor_pos_i(motor_pos), .ctl_o(ctl_o),
      .status_o(status_o), .p1_rise_pos_o(pos_o[0]),
      .p1_fall_pos_o(pos_o[1]), .p2_rise_pos_o(pos_o[2]),
      .p2_fall_pos_o(pos_o[3]));
   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // one-cycle strobe, readback visible one cycle later
   task automatic write_ctl(input logic [15:0] v);
      @(posedge clk_i);
      #1;
      ctl_wr_i = 1'b1;
      ctl_wdata_i = v;
      @(posedge clk_i);
      #1;
      ctl_wr_i = 1'b0;
      check("ctl_o", {16'h0000, ctl_o}, {16'h0000, v});
   endtask : write_ctl
   // changes one trigger and notes the position seen in that cycle
   task automatic drive(input int b, input logic v);
      @(posedge clk_i);
      #1;
      trig[b] = v;
      p = motor_pos;
      @(posedge clk_i);
      #1;
   endtask : drive
   task automatic check_all(input logic [15:0] sts);
      check("status_o", {16'h0000, status_o}, {16'h0000, sts});
      for (int i = 0; i < 4; i++) begin
         check("position", pos_o[i], exp_pos[i]);
      end
   endtask : check_all
   task automatic final_report;
      if (mismatches == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge clk_i);
      #1;
      srst_i = 1'b0;
      check_all(16'h0000);
      // single mode, rising edge only, fast input one
      write_ctl(16'h0010);
      write_ctl(16'h0011);
      check_all(16'h0001);
      drive(0, 1'b1);
      exp_pos[0] = p;
      check_all(16'h0003);
      drive(0, 1'b0); // falling polarity is off
      drive(0, 1'b1); // a second rise must be ignored
      check_all(16'h0003);
      drive(0, 1'b0);
      write_ctl(16'h0000); // disable clears flags, keeps positions
      check_all(16'h0000);
      write_ctl(16'h0010);
      write_ctl(16'h0011); // re-arm
      drive(0, 1'b1);
      exp_pos[0] = p;
      check_all(16'h0003);
      drive(0, 1'b0);
      // continuous, both edges, each probe with each source
      for (int k = 0; k < 4; k++) begin
         int pr;
         int src;
         logic [15:0] w;
         pr = k / 2;
         src = k % 2;
         w = (16'h0033 | 16'(src << 2)) << (8 * pr);
         write_ctl(16'h0000);
         write_ctl(w & ~(16'h0001 << (8 * pr)));
         write_ctl(w);
         drive(src != 0 ? pr : 2, 1'b1); // unselected source toggles
         drive(src != 0 ? pr : 2, 1'b0);
         check_all(16'h0001 << (8 * pr));
         for (int r = 0; r < 2; r++) begin
            drive(src != 0 ? 2 : pr, 1'b1);
            exp_pos[2 * pr] = p;
            drive(src != 0 ? 2 : pr, 1'b0);
            exp_pos[2 * pr + 1] = p;
         end
         check_all(16'h0007 << (8 * pr));
      end
      write_ctl(16'h0000);
      final_report();
   end
endmodule : probe_position_latch_tb
